// *** core/spm_link.sv ***
// Slave-side bit shifter running on the serial clock from the far master
`timescale 1ns/100ps
module spm_link
	import spm_pkg::*;
(
	input  wire logic sck_i,   // Serial clock from the far master
	input  wire logic sys_rst, // Asynchronous reset, active high
	spm_link_if.link  lk       // Connection to the port core
);

	logic       smp_clk;      // Clock whose rising edge samples data
	logic       lk_rst;       // Reset of the bit counter
	logic [2:0] cnt_reg;      // Bits received in the current byte
	logic [2:0] out_idx_reg;  // Bit counter as seen by the output edge
	logic [6:0] rx_sh_reg;    // Partial received byte
	logic [7:0] rx_hold_reg;  // Completed received byte
	logic       done_tgl_reg; // Byte completion event

	// Sample edge follows polarity and phase
	assign smp_clk = sck_i ^ lk.cpol ^ lk.cpha;
	assign lk_rst  = sys_rst | lk.hold;

	always_ff @(posedge smp_clk or posedge lk_rst) begin
		if (lk_rst) begin
			cnt_reg   <= 3'h0;
			rx_sh_reg <= 7'h00;
		end else begin
			cnt_reg   <= cnt_reg + 3'h1;
			// first bit lands in the top
			rx_sh_reg <= {rx_sh_reg[5:0], lk.mosi};
		end
	end

	// Completion survives the hold so the core never sees a false event
	always_ff @(posedge smp_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_hold_reg  <= BYTE_RST;
			done_tgl_reg <= 1'b0;
		end else if (cnt_reg == LAST_BIT) begin
			rx_hold_reg  <= {rx_sh_reg, lk.mosi};
			done_tgl_reg <= ~done_tgl_reg;
		end
	end

	// Output index advances on the opposite edge
	always_ff @(negedge smp_clk or posedge lk_rst) begin
		if (lk_rst) begin
			out_idx_reg <= 3'h0;
		end else begin
			out_idx_reg <= cnt_reg;
		end
	end

	// slave data out, top bit first
	assign lk.miso     = lk.tx_byte[LAST_BIT - out_idx_reg];
	assign lk.rx_byte  = rx_hold_reg;
	assign lk.done_tgl = done_tgl_reg;

	byte_count_a: assert property (
		@(posedge smp_clk) disable iff (lk_rst)
		$changed(done_tgl_reg) |-> $past(cnt_reg) == LAST_BIT)
		else $error("byte completed at wrong bit count");

endmodule // spm_link

// *** core/spm_link_if.sv ***
// Signals between the port core and the slave link logic
`timescale 1ns/100ps
interface spm_link_if;
	logic [7:0] tx_byte;  // Byte to send as slave, stable while active
	logic [7:0] rx_byte;  // Last byte received as slave
	logic       done_tgl; // Toggles once per received byte
	logic       hold;     // Holds the link bit counters and shifter idle and cleared
	logic       cpol;     // Clock polarity
	logic       cpha;     // Clock phase
	logic       mosi;     // Data line from the far master
	logic       miso;     // Data bit to drive back to the master

	modport core (
		output tx_byte, hold, cpol, cpha, mosi,
		input  rx_byte, done_tgl, miso
	);
	modport link (
		input  tx_byte, hold, cpol, cpha, mosi,
		output rx_byte, done_tgl, miso
	);
endinterface // spm_link_if

// *** core/spm_pkg.sv ***
// Constants and types shared by the serial port core and its link logic
package spm_pkg;

	// ---------------------------------------------------------------
	// Select-mode field encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] SEL_3WIRE   = 2'h0; // Three-wire, select unused
	localparam logic [1:0] SEL_4W_IN   = 2'h1; // Select is an input
	localparam int         SEL_OUT_BIT = 1;    // Upper bit: select is output
	localparam int         SEL_LVL_BIT = 0;    // Lower bit: output level

	// ---------------------------------------------------------------
	// Byte framing
	// ---------------------------------------------------------------
	localparam int         BYTE_BITS  = 8;            // Bits per transfer
	localparam int         BYTE_EDGES = 2 * BYTE_BITS; // Clock edges per byte
	localparam logic [3:0] LAST_EDGE  = 4'hf;         // Index of final edge
	localparam logic [2:0] LAST_BIT   = 3'h7;         // Index of final bit

	// ---------------------------------------------------------------
	// Timing of the generated serial clock
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;  // System clock period
	localparam int SCK_HALF_NS   = 160; // Least half period of the clock
	localparam int SCK_HALF_CYC  =
		(SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCK_HALF_MIN  = 3;   // Covers the input synchroniser

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] BYTE_RST = 8'h00; // Data registers at reset

	// Master sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h1,
		ST_SHIFT = 2'h2
	} spm_state_t;

endpackage

// *** core/spm_top.sv ***
// Serial port core: pin directions, select modes, master and slave bytes
`timescale 1ns/100ps
module spm_top
	import spm_pkg::*;
#(
	parameter int unsigned SCK_HALF = SCK_HALF_CYC // Half period, cycles
)(
	input  wire logic       clk,                  // System clock
	input  wire logic       sys_rst,              // Async reset, high
	input  wire logic       sck_i,                // Serial clock pin in
	output logic            sck_o,                // Serial clock pin out
	output logic            sck_oe_n,             // Clock pin enable
	input  wire logic       mosi_i,               // Master data pin in
	output logic            mosi_o,               // Master data pin out
	output logic            mosi_oe_n,            // Master data enable
	input  wire logic       miso_i,               // Slave data pin in
	output logic            miso_o,               // Slave data pin out
	output logic            miso_oe_n,            // Slave data enable
	input  wire logic       slave_select_i,       // Select pin in
	output logic            slave_select_o,       // Select pin out
	output logic            slave_select_oe_n,    // Select pin enable
	output logic            ss_pin_mapped,        // Select routed to pin
	input  wire logic       ctl_wr,               // Write enable bits
	input  wire logic       ctl_port_enable,      // Port enable value
	input  wire logic       ctl_master_enable,    // Master enable value
	input  wire logic [1:0] select_mode_field,    // Select mode
	input  wire logic       clock_phase,          // Latch edge choice
	input  wire logic       clock_polarity,       // Idle clock level
	input  wire logic       tx_wr,                // Write transmit byte
	input  wire logic [7:0] tx_data,              // Transmit byte
	input  wire logic       done_clr,             // Clear done flag
	input  wire logic       fault_clr,            // Clear fault flag
	input  wire logic       wcol_clr,             // Clear collision flag
	output logic            port_enable,          // Port enabled
	output logic            master_enable,        // Acting as master
	output logic            transfer_done_flag,   // Byte finished
	output logic            mode_fault_flag,      // Mode fault seen
	output logic            write_collision_flag, // Write while full
	output logic [7:0]      rx_data,              // Last received byte
	output logic            busy                  // Master byte running
);

	// Refuse half periods the counter or synchroniser cannot serve
	if (SCK_HALF < SCK_HALF_MIN || SCK_HALF > 255) begin : g_half_chk
		$error("SCK_HALF out of range");
	end

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	spm_link_if lk ();

	spm_state_t state_reg;
	logic [7:0] half_cnt_reg;
	logic [3:0] edge_cnt_reg;
	logic [7:0] shreg_reg;
	logic [7:0] rxsh_reg;
	logic [7:0] tx_buf_reg;
	logic       tx_full_reg;
	logic [7:0] slv_tx_reg;
	logic       hold_reg;
	logic       ss_meta_reg, ss_s_reg, ss_d_reg;
	logic       miso_meta_reg, miso_s_reg;
	logic       dn_meta_reg, dn_s_reg, dn_d_reg;
	logic       master_act;
	logic       slave_act;
	logic       selected;
	logic       ss_fall;
	logic       fault_ev;
	logic       start;
	logic       slv_take;
	logic       take;
	logic       edge_now;
	logic       master_done;
	logic       slave_done;
	logic       byte_done;
	logic       smp_now;
	logic       drv_now;
	logic [7:0] rx_next;

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------

	// Select and slave data pins, plus slave completion toggle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ss_meta_reg   <= 1'b1;
			ss_s_reg      <= 1'b1;
			ss_d_reg      <= 1'b1;
			miso_meta_reg <= 1'b0;
			miso_s_reg    <= 1'b0;
			dn_meta_reg   <= 1'b0;
			dn_s_reg      <= 1'b0;
			dn_d_reg      <= 1'b0;
		end else begin
			ss_meta_reg   <= slave_select_i;
			ss_s_reg      <= ss_meta_reg;
			ss_d_reg      <= ss_s_reg;
			miso_meta_reg <= miso_i;
			miso_s_reg    <= miso_meta_reg;
			dn_meta_reg   <= lk.done_tgl;
			dn_s_reg      <= dn_meta_reg;
			dn_d_reg      <= dn_s_reg;
		end
	end

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------

	// so it must be alone on the bus
	// otherwise a low select selects it
	function automatic logic sel_ok(input logic [1:0] md, input logic ss);
		sel_ok = (md == SEL_3WIRE) | ~ss;
	endfunction

	assign master_act = port_enable & master_enable;
	assign slave_act  = port_enable & ~master_enable;
	assign selected   = sel_ok(select_mode_field, ss_s_reg);
	assign ss_fall    = ss_d_reg & ~ss_s_reg;
	// select fall ends mastership in mode 01
	assign fault_ev   = master_act & (select_mode_field == SEL_4W_IN)
		& ss_fall;
	assign slave_done = dn_s_reg ^ dn_d_reg;

	// ---------------------------------------------------------------
	// Master sequencer
	// ---------------------------------------------------------------
	assign start    = master_act & tx_full_reg & (state_reg == ST_IDLE)
		& ~fault_ev;
	assign edge_now = (state_reg == ST_SHIFT)
		& (half_cnt_reg == 8'(SCK_HALF - 1));
	assign smp_now  = edge_now & (edge_cnt_reg[0] == clock_phase);
	assign drv_now  = edge_now & (edge_cnt_reg[0] != clock_phase)
		& (edge_cnt_reg != 4'h0) & (edge_cnt_reg != LAST_EDGE);
	assign rx_next  = {rxsh_reg[6:0], miso_s_reg};
	assign master_done = edge_now & (edge_cnt_reg == LAST_EDGE)
		& ~fault_ev & master_act;
	assign byte_done   = master_done | (slave_done & slave_act);

	// State and edge counting
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg    <= ST_IDLE;
			half_cnt_reg <= 8'h00;
			edge_cnt_reg <= 4'h0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					half_cnt_reg <= 8'h00;
					edge_cnt_reg <= 4'h0;
					if (start) begin
						state_reg <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (fault_ev | ~master_act | master_done) begin
						state_reg <= ST_IDLE;
					end else if (edge_now) begin
						half_cnt_reg <= 8'h00;
						edge_cnt_reg <= edge_cnt_reg + 4'h1;
					end else begin
						half_cnt_reg <= half_cnt_reg + 8'h01;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// bits leave and arrive on alternate edges
	// Master shifters: transmit on drive edges, receive on sample edges
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			shreg_reg <= BYTE_RST;
			rxsh_reg  <= BYTE_RST;
		end else begin
			if (start) begin
				shreg_reg <= tx_buf_reg;
			end else if (drv_now) begin
				shreg_reg <= {shreg_reg[6:0], 1'b0};
			end
			if (smp_now) begin
				rxsh_reg <= rx_next;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sck_o <= 1'b0;
		end else if (state_reg != ST_SHIFT || master_done) begin
			sck_o <= clock_polarity;
		end else if (edge_now) begin
			sck_o <= ~sck_o;
		end
	end

	// ---------------------------------------------------------------
	// Transmit buffer and slave transmit byte
	// ---------------------------------------------------------------
	assign slv_take = tx_full_reg & (hold_reg | slave_done) & slave_act;
	assign take     = start | slv_take;

	// Double-buffered transmit byte; writes while full are refused
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_buf_reg  <= BYTE_RST;
			tx_full_reg <= 1'b0;
			slv_tx_reg  <= BYTE_RST;
		end else begin
			if (tx_wr && !tx_full_reg) begin
				tx_buf_reg  <= tx_data;
				tx_full_reg <= 1'b1;
			end else if (take) begin
				tx_full_reg <= 1'b0;
			end
			if (slv_take) begin
				slv_tx_reg <= tx_buf_reg;
			end
		end
	end

	// Link logic held cleared unless this port is a selected slave
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_reg <= 1'b1;
		end else begin
			// release after select fall restarts the count
			hold_reg <= ~(slave_act & selected);
		end
	end

	// ---------------------------------------------------------------
	// Control bits and flags
	// ---------------------------------------------------------------

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			port_enable   <= 1'b0;
			master_enable <= 1'b0;
		end else if (fault_ev) begin
			port_enable   <= 1'b0;
			master_enable <= 1'b0;
		end else if (ctl_wr) begin
			port_enable   <= ctl_port_enable;
			master_enable <= ctl_master_enable;
		end
	end

	// done flag, setting wins over clearing
	// fault flag raised with the enables dropped
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			transfer_done_flag   <= 1'b0;
			mode_fault_flag      <= 1'b0;
			write_collision_flag <= 1'b0;
		end else begin
			transfer_done_flag   <= byte_done
				| (transfer_done_flag & ~done_clr);
			mode_fault_flag      <= fault_ev
				| (mode_fault_flag & ~fault_clr);
			write_collision_flag <= (tx_wr & tx_full_reg)
				| (write_collision_flag & ~wcol_clr);
		end
	end

	// Received byte from whichever end finished
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_data <= BYTE_RST;
			busy    <= 1'b0;
		end else begin
			if (master_done) begin
				rx_data <= smp_now ? rx_next : rxsh_reg;
			end else if (slave_done && slave_act) begin
				rx_data <= lk.rx_byte;
			end
			busy <= (state_reg == ST_SHIFT) & ~master_done & ~fault_ev;
		end
	end

	// ---------------------------------------------------------------
	// Pin drivers
	// ---------------------------------------------------------------

	// Direction and select pin registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mosi_oe_n         <= 1'b1;
			sck_oe_n          <= 1'b1;
			miso_oe_n         <= 1'b1;
			slave_select_o    <= 1'b1;
			slave_select_oe_n <= 1'b1;
			ss_pin_mapped     <= 1'b0;
		end else begin
			mosi_oe_n         <= ~master_act;
			sck_oe_n          <= ~master_act;
			miso_oe_n         <= ~(slave_act & selected);
			// select output follows lower mode bit
			slave_select_o    <= select_mode_field[SEL_LVL_BIT];
			slave_select_oe_n <= ~select_mode_field[SEL_OUT_BIT];
			// pin routed in every four-wire mode
			ss_pin_mapped     <= (select_mode_field != SEL_3WIRE);
		end
	end

	// master data from shifter top bit
	assign mosi_o = shreg_reg[7];
	// slave data from the link shifter
	assign miso_o = lk.miso;

	// ---------------------------------------------------------------
	// Slave link
	// ---------------------------------------------------------------
	assign lk.tx_byte = slv_tx_reg;
	assign lk.hold    = hold_reg;
	assign lk.cpol    = clock_polarity;
	assign lk.cpha    = clock_phase;
	assign lk.mosi    = mosi_i;

	spm_link u_link (
		.sck_i   (sck_i),
		.sys_rst (sys_rst),
		.lk      (lk.link)
	);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	mosi_dir_a: assert property (
		ctl_wr ##1 (port_enable && !master_enable) |=> mosi_oe_n)
		else $error("data-out driven while slave");

	miso_dir_a: assert property (
		master_enable |=> miso_oe_n)
		else $error("data-in driven while master");

	mosi_msb_a: assert property (
		start |=> mosi_o == $past(tx_buf_reg[7]))
		else $error("first bit is not the top bit");

	miso_hiz_a: assert property (
		(!port_enable || (select_mode_field == SEL_4W_IN && ss_s_reg))
		|=> miso_oe_n)
		else $error("data-in driven while off or deselected");

	sck_toggle_a: assert property (
		(edge_now && !master_done && master_act && !fault_ev)
		|=> sck_o != $past(sck_o))
		else $error("serial clock missed an edge");

	hold_sel_a: assert property (
		(select_mode_field == SEL_4W_IN && ss_s_reg) |=> hold_reg)
		else $error("deselected slave not held");

	ss_out_a: assert property (
		select_mode_field[SEL_OUT_BIT] |=> !slave_select_oe_n
		&& slave_select_o == $past(select_mode_field[SEL_LVL_BIT]))
		else $error("select output level wrong");

	ss_map_a: assert property (
		##1 ss_pin_mapped == ($past(select_mode_field) != SEL_3WIRE))
		else $error("select pin mapping wrong");

	fault_clear_a: assert property (
		fault_ev |=> mode_fault_flag && !port_enable && !master_enable
		&& state_reg == ST_IDLE)
		else $error("mode fault did not disable the port");

	done_set_a: assert property (
		byte_done |=> transfer_done_flag)
		else $error("done flag not set after a byte");

	byte_len_a: assert property (
		start |-> ##[32:300] (state_reg == ST_IDLE))
		else $error("master byte did not finish in time");

endmodule // spm_top

// *** dv/spm_far.sv ***
// Far-side serial device model: answers as slave, drives as master
`timescale 1ns/100ps
module spm_far (
	input  wire logic       sck,    // Clock level on the wire
	input  wire logic       mosi,   // Master data on the wire
	input  wire logic       miso,   // Slave data on the wire
	output logic            sck_d,  // Clock driven as master
	output logic            mosi_d, // Data driven as master
	output logic            miso_d, // Data driven as slave
	output logic            ss_d,   // Select driven, low selects
	output logic [7:0]      sr      // Slave shift register
);
	logic cap; // Bit taken on the leading edge

	// Idle levels: clock still, select high
	initial begin
		sck_d = 1'b0;
		mosi_d = 1'b0;
		ss_d = 1'b1;
		sr = 8'h00;
		cap = 1'b0;
	end

	// sample on rise, shift on fall
	always @(posedge sck) cap = mosi;
	always @(negedge sck) sr = {sr[6:0], cap};
	// sole slave drives its top bit
	assign miso_d = sr[7];

	// Select line set by the bench
	task automatic sel(input logic v);
		ss_d = v;
	endtask

	// clock runs only inside a frame
	task automatic frame(input logic [7:0] b, input int n,
		output logic [7:0] r);
		r = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			mosi_d = b[i];
			#62.5 r[i] = miso;
			sck_d = 1'b1;
			#62.5 sck_d = 1'b0;
		end
		mosi_d = ~mosi_d; // Released data shows no stale bit
	endtask
endmodule // spm_far

// *** dv/spm_top_bench.sv ***
// Self-checking bench for the serial port core
`timescale 1ns/100ps
module spm_top_bench;
	import spm_pkg::*;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       ctl_wr = 1'b0, ctl_port_enable = 1'b0;
	logic       ctl_master_enable = 1'b0, tx_wr = 1'b0;
	logic       done_clr = 1'b0, fault_clr = 1'b0;
	logic       clock_polarity = 1'b0, wcol_clr = 1'b0;
	logic       write_collision_flag;
	logic [1:0] select_mode_field = 2'h0;
	logic [7:0] tx_data = 8'h00, r;
	logic       sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
	logic       slave_select_o, slave_select_oe_n, ss_pin_mapped;
	logic       port_enable, master_enable, transfer_done_flag;
	logic       mode_fault_flag, busy;
	logic [7:0] rx_data;
	logic       f_sck, f_mosi, f_miso, f_ss;
	logic [7:0] f_sr;
	wire        sck_w = sck_oe_n ? f_sck : sck_o;
	wire        mosi_w = mosi_oe_n ? f_mosi : mosi_o;
	wire        miso_w = miso_oe_n ? f_miso : miso_o;
	wire        ss_w = slave_select_oe_n ? f_ss : slave_select_o;
	int         error_cnt = 0, n_tests = 0;

	always #20 clk = ~clk;

	spm_top #(.SCK_HALF(4)) u_spm_top (.clk, .sys_rst, .sck_i(sck_w),
		.sck_o, .sck_oe_n, .mosi_i(mosi_w), .mosi_o, .mosi_oe_n,
		.miso_i(miso_w), .miso_o, .miso_oe_n, .slave_select_i(ss_w),
		.slave_select_o, .slave_select_oe_n, .ss_pin_mapped, .ctl_wr,
		.ctl_port_enable, .ctl_master_enable, .select_mode_field,
		.clock_phase(1'b0), .clock_polarity, .tx_wr, .tx_data,
		.done_clr, .fault_clr, .wcol_clr, .port_enable,
		.master_enable, .transfer_done_flag, .mode_fault_flag,
		.write_collision_flag, .rx_data, .busy);

	spm_far u_spm_far (.sck(sck_w), .mosi(mosi_w), .miso(miso_w),
		.sck_d(f_sck), .mosi_d(f_mosi), .miso_d(f_miso), .ss_d(f_ss),
		.sr(f_sr));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] s, e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask

	task automatic ctl(input logic pe, me, input logic [1:0] md);
		@(posedge clk);
		select_mode_field <= md;
		ctl_port_enable <= pe;
		ctl_master_enable <= me;
		ctl_wr <= 1'b1;
		@(posedge clk);
		ctl_wr <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic put(input logic [7:0] b);
		@(posedge clk);
		tx_data <= b;
		tx_wr <= 1'b1;
		@(posedge clk);
		tx_wr <= 1'b0;
	endtask

	task automatic wait_done;
		for (int k = 0; k < 400 && transfer_done_flag !== 1'b1; k++)
			@(negedge clk);
		chk("done", transfer_done_flag, 1'b1);
		@(posedge clk);
		done_clr <= 1'b1;
		@(posedge clk);
		done_clr <= 1'b0;
		@(negedge clk);
		chk("done_clr", transfer_done_flag, 1'b0);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_modes;
		@(negedge clk);
		chk("miso_oe_rst", miso_oe_n, 1'b1);
		chk("mosi_oe_rst", mosi_oe_n, 1'b1);
		for (int m = 0; m < 4; m++) begin
			ctl(1'b0, 1'b0, m[1:0]);
			@(negedge clk);
			chk("ss_map", ss_pin_mapped, m != 0);
			chk("ss_oe", slave_select_oe_n, !m[1]);
			if (m[1])
				chk("ss_out", slave_select_o, m[0]);
		end
	endtask

	task automatic t_fault;
		ctl(1'b1, 1'b1, 2'h1);
		u_spm_far.sel(1'b0);
		repeat (6) @(negedge clk);
		chk("fault_pe", port_enable, 1'b0);
		chk("fault_me", master_enable, 1'b0);
		chk("fault_flag", mode_fault_flag, 1'b1);
		u_spm_far.sel(1'b1);
		@(posedge clk);
		fault_clr <= 1'b1;
		@(posedge clk);
		fault_clr <= 1'b0;
		@(negedge clk);
		chk("fault_clr", mode_fault_flag, 1'b0);
	endtask

	task automatic t_master;
		// output select used only as master
		ctl(1'b1, 1'b1, 2'h2);
		u_spm_far.sr = 8'h3c;
		@(negedge clk);
		chk("sck_oe", sck_oe_n, 1'b0);
		chk("mosi_oe", mosi_oe_n, 1'b0);
		chk("miso_oe", miso_oe_n, 1'b1);
		put(8'ha5);
		repeat (3) @(negedge clk);
		chk("busy", busy, 1'b1);
		wait_done();
		chk("busy_end", busy, 1'b0);
		chk("m_rx", rx_data, 8'h3c);
		chk("m_tx", f_sr, 8'ha5);
		chk("sck_idle", sck_o, 1'b0);
	endtask

	task automatic t_slave4;
		ctl(1'b0, 1'b0, 2'h1);
		ctl(1'b1, 1'b0, 2'h1);
		put(8'h96);
		u_spm_far.frame(8'h33, 3, r);
		@(negedge clk);
		chk("unsel_oe", miso_oe_n, 1'b1);
		u_spm_far.sel(1'b0);
		#250;
		chk("sel_oe", miso_oe_n, 1'b0);
		u_spm_far.frame(8'h5a, 8, r);
		u_spm_far.sel(1'b1);
		wait_done();
		chk("s4_rx", rx_data, 8'h5a);
		chk("s4_tx", r, 8'h96);
	endtask

	task automatic t_slave3;
		ctl(1'b0, 1'b0, 2'h0);
		// Byte written before enabling, so the link loads it on release
		put(8'h3c);
		ctl(1'b1, 1'b0, 2'h0);
		@(negedge clk);
		chk("s3_oe", miso_oe_n, 1'b0);
		chk("s3_msb", miso_o, 1'b0);
		u_spm_far.frame(8'h81, 8, r);
		wait_done();
		chk("s3_rx", rx_data, 8'h81);
		chk("s3_tx", r, 8'h3c);
		ctl(1'b0, 1'b0, 2'h0);
		@(negedge clk);
		chk("off_oe", miso_oe_n, 1'b1);
	endtask

	task automatic t_misc;
		@(posedge clk);
		clock_polarity <= 1'b1;
		ctl(1'b1, 1'b1, 2'h2);
		@(negedge clk);
		chk("sck_pol", sck_o, 1'b1);
		ctl(1'b0, 1'b0, 2'h2);
		clock_polarity <= 1'b0;
		put(8'h11);
		put(8'h22);
		@(negedge clk);
		chk("wcol_set", write_collision_flag, 1'b1);
		@(posedge clk);
		wcol_clr <= 1'b1;
		@(posedge clk);
		wcol_clr <= 1'b0;
		@(negedge clk);
		chk("wcol_clr", write_collision_flag, 1'b0);
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Main sequence after reset
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		t_modes();
		t_fault();
		t_master();
		t_slave4();
		t_slave3();
		t_misc();
		test_done();
	end

	// Watchdog cuts a hang short
	initial begin
		#300000;
		error_cnt++;
		test_done();
	end
endmodule // spm_top_bench
